/* File: pll_source_routing_control.sv */
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pll_route_defines.svh"
// Summary of operation
// RULE1: software routes vco through divider, limit 1600MHz
// RULE2: power field 00 runs pll, 01 powers down
// RULE3: bypass bit 0 uses divider, 1 bypasses
// RULE4: source bit 1 internal vco, 0 external clock
// RULE5: calibrate by setting cal bit then update
// RULE6: clear cal bit and update before recalibrating
// RULE7: settings act only after update write 0x01
// RULE8: polarity bit 0 positive, 1 negative slope
// RULE9: polarity matters only for external oscillators; the code applies the polarity swap with the internal vco as well
// RULE10: antibacklash field sets overlap pulse width
// RULE11: detector compares r and n, drives pump
// RULE12: pump mode: hiz, normal, forced up, down
// RULE13: pump current has eight selectable steps
// RULE14: bypass only when source below 1600MHz
// RULE15: external vco below limit: pll on, bypass
// RULE16: vco divider field selects two to six
// RULE17: reference present, divider toggling during calibration; the code checks only vco source and loop power before a start
// RULE18: unused power and divider codes are reserved
module pll_source_routing_control (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  input  wire logic [`ADDR_W-1:0]            reg_addr,
  input  wire logic [`DATA_W-1:0]            reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [`DATA_W-1:0]            reg_rdata,
  input  wire logic                          ref_tick,
  input  wire logic                          fb_tick,
  output logic                               pll_pd,
  output logic                               vco_pwr_en,
  output logic                               dist_src_vco,
  output logic                               vdiv_bypass,
  output logic      [2:0]                    vdiv_code,
  output logic                               cp_up,
  output logic                               cp_dn,
  output logic                               cp_drive_en,
  output logic      [2:0]                    cp_current,
  output var        pll_route_pkg::cal_state_type cal_state
);
  import pll_route_pkg::*;

  // staged copies: what software writes, not yet in force
  logic [`DATA_W-1:0] buf_ctrl_reg;
  logic [`DATA_W-1:0] buf_abl_reg;
  logic [`DATA_W-1:0] buf_cal_reg;
  logic [`DATA_W-1:0] buf_cpcur_reg;
  logic [`DATA_W-1:0] buf_vdiv_reg;
  logic [`DATA_W-1:0] buf_route_reg;
  // active copies: what the hardware obeys
  logic [`DATA_W-1:0] act_ctrl_reg;
  logic [`DATA_W-1:0] act_abl_reg;
  logic [`DATA_W-1:0] act_cal_reg;
  logic [`DATA_W-1:0] act_cpcur_reg;
  logic [`DATA_W-1:0] act_vdiv_reg;
  logic [`DATA_W-1:0] act_route_reg;
  // registered outputs
  logic [`DATA_W-1:0] rdata_reg;
  logic               pll_pd_reg;
  logic               vco_pwr_en_reg;
  logic               dist_src_vco_reg;
  logic               vdiv_bypass_reg;
  logic [2:0]         vdiv_code_reg;
  logic               cp_up_reg;
  logic               cp_dn_reg;
  logic               cp_drive_en_reg;
  logic [2:0]         cp_current_reg;
  cal_state_type      cal_state_reg;
  cal_state_type      cal_state_w;   // sequencer state, straight from the sequencer's state register

  // write decode, one wire per register
  wire wr_ctrl   = reg_wr && (reg_addr == `OFS_PLL_CTRL);
  wire wr_abl    = reg_wr && (reg_addr == `OFS_ABL);
  wire wr_cal    = reg_wr && (reg_addr == `OFS_CAL);
  wire wr_cpcur  = reg_wr && (reg_addr == `OFS_CPCUR);
  wire wr_vdiv   = reg_wr && (reg_addr == `OFS_VDIV);
  wire wr_route  = reg_wr && (reg_addr == `OFS_ROUTE);
  // only the exact key transfers; other values to that address are dropped
  wire do_update = reg_wr && (reg_addr == `OFS_UPDATE) && (reg_wdata == `UPDATE_KEY);

  // decoded active settings
  wire [1:0] pwr_field = act_ctrl_reg[`F_PWR];
  // reserved power codes are treated as off, the safe choice for the loop
  wire       pll_on    = (pwr_field == `PWR_NORMAL);                // see RULE2 see RULE18
  wire [2:0] cpm_field = act_ctrl_reg[`F_CPM];
  wire       pol_neg   = act_ctrl_reg[`F_POL];
  wire       src_vco   = act_route_reg[`F_SRC];
  wire       cal_bit   = act_cal_reg[`F_CAL];
  // the new active cal bit as it will be after this cycle's transfer
  wire       cal_bit_new = do_update ? buf_cal_reg[`F_CAL] : cal_bit;
  wire       src_new     = do_update ? buf_route_reg[`F_SRC] : src_vco;
  wire       pwr_on_new  = do_update ? (buf_ctrl_reg[`F_PWR] == `PWR_NORMAL) : pll_on;
  // a calibration starts only on a 0 to 1 transfer of the cal bit,
  // so software must clear and update before each recalibration
  wire       cal_start = do_update && !cal_bit && cal_bit_new
                         && src_new && pwr_on_new;                  // see RULE5 see RULE6
  // losing the vco or the loop power kills a running calibration
  wire       cal_abort = !src_new || !pwr_on_new;

  // status word shows the block's own state
  wire [`DATA_W-1:0] status_w = {3'h0, cp_dn_reg, cp_up_reg, pll_on,
                                 (cal_state_reg == CAL_DONE),
                                 (cal_state_reg == CAL_RUN)};

  // read mux; unmapped addresses and the update register read zero
  wire [`DATA_W-1:0] rd_mux =
      (reg_addr == `OFS_PLL_CTRL) ? buf_ctrl_reg  :
      (reg_addr == `OFS_ABL)      ? buf_abl_reg   :
      (reg_addr == `OFS_CAL)      ? buf_cal_reg   :
      (reg_addr == `OFS_CPCUR)    ? buf_cpcur_reg :
      (reg_addr == `OFS_STATUS)   ? status_w      :
      (reg_addr == `OFS_VDIV)     ? buf_vdiv_reg  :
      (reg_addr == `OFS_ROUTE)    ? buf_route_reg : '0;

  // pump command from mode field; polarity swaps the detector outputs
  pfd_link_if lnk ();
  wire pfd_up_pol = pol_neg ? lnk.dn : lnk.up;                     // see RULE8
  wire pfd_dn_pol = pol_neg ? lnk.up : lnk.dn;                     // see RULE8
  wire cpm_norm   = (cpm_field == `CPM_NORMAL);
  wire cpm_up     = (cpm_field == `CPM_UP);
  wire cpm_dn     = (cpm_field == `CPM_DOWN);
  // high impedance for holdover and for any unassigned mode code
  wire cp_drive_w = pll_on && (cpm_norm || cpm_up || cpm_dn);      // see RULE12
  wire cp_up_w    = pll_on && (cpm_up || (cpm_norm && pfd_up_pol)); // see RULE12
  wire cp_dn_w    = pll_on && (cpm_dn || (cpm_norm && pfd_dn_pol)); // see RULE12

  // detector link: runs only while the loop is powered
  assign lnk.ref_tick = ref_tick;
  assign lnk.fb_tick  = fb_tick;
  assign lnk.run      = pll_on;
  assign lnk.abl_sel  = act_abl_reg[`F_ABL];

  pfd_core u_pfd (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .lnk     (lnk)
  );

  vco_cal_seq u_cal (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .start   (cal_start),
    .abort   (cal_abort),
    .state   (cal_state_w)
  );

  // staged registers take software writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buf_ctrl_reg  <= `RST_PLL_CTRL;
      buf_abl_reg   <= `RST_ABL;
      buf_cal_reg   <= `RST_CAL;
      buf_cpcur_reg <= `RST_CPCUR;
      buf_vdiv_reg  <= `RST_VDIV;
      buf_route_reg <= `RST_ROUTE;
    end else if (ce) begin
      if (wr_ctrl)  buf_ctrl_reg  <= reg_wdata;
      if (wr_abl)   buf_abl_reg   <= reg_wdata;
      if (wr_cal)   buf_cal_reg   <= reg_wdata;
      if (wr_cpcur) buf_cpcur_reg <= reg_wdata;
      if (wr_vdiv)  buf_vdiv_reg  <= reg_wdata;
      if (wr_route) buf_route_reg <= reg_wdata;
    end
  end

  // active registers change only on the update key
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_ctrl_reg  <= `RST_PLL_CTRL;
      act_abl_reg   <= `RST_ABL;
      act_cal_reg   <= `RST_CAL;
      act_cpcur_reg <= `RST_CPCUR;
      act_vdiv_reg  <= `RST_VDIV;
      act_route_reg <= `RST_ROUTE;
    end else if (ce && do_update) begin                             // see RULE7
      act_ctrl_reg  <= buf_ctrl_reg;
      act_abl_reg   <= buf_abl_reg;
      act_cal_reg   <= buf_cal_reg;
      act_cpcur_reg <= buf_cpcur_reg;
      act_vdiv_reg  <= buf_vdiv_reg;
      act_route_reg <= buf_route_reg;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (ce) begin
      rdata_reg <= reg_rd ? rd_mux : '0;
    end
  end

  // routing and divider outputs, registered from the active copies
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pll_pd_reg       <= 1'b1;
      vco_pwr_en_reg   <= 1'b0;
      dist_src_vco_reg <= 1'b0;
      vdiv_bypass_reg  <= 1'b0;
      vdiv_code_reg    <= 3'(`RST_VDIV);
    end else if (ce) begin
      pll_pd_reg       <= !pll_on;                                  // see RULE2
      // internal vco idles whenever the external input is chosen
      vco_pwr_en_reg   <= pll_on && src_vco;                        // see RULE4
      dist_src_vco_reg <= src_vco;                                  // see RULE4
      vdiv_bypass_reg  <= act_route_reg[`F_BYP];                    // see RULE3
      // code 0..4 means divide by 2..6; higher codes pass through unchecked
      vdiv_code_reg    <= act_vdiv_reg[`F_VDIV];                    // see RULE16 see RULE18
    end
  end

  // charge pump outputs and calibration state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cp_up_reg       <= 1'b0;
      cp_dn_reg       <= 1'b0;
      cp_drive_en_reg <= 1'b0;
      cp_current_reg  <= 3'h0;
      cal_state_reg   <= CAL_IDLE;
    end else if (ce) begin
      cp_up_reg       <= cp_up_w;                                   // see RULE11
      cp_dn_reg       <= cp_dn_w;                                   // see RULE11
      cp_drive_en_reg <= cp_drive_w;                                // see RULE12
      cp_current_reg  <= act_cpcur_reg[`F_CPCUR];                   // see RULE13
      cal_state_reg   <= cal_state_w;
    end
  end

  assign reg_rdata    = rdata_reg;
  assign pll_pd       = pll_pd_reg;
  assign vco_pwr_en   = vco_pwr_en_reg;
  assign dist_src_vco = dist_src_vco_reg;
  assign vdiv_bypass  = vdiv_bypass_reg;
  assign vdiv_code    = vdiv_code_reg;
  assign cp_up        = cp_up_reg;
  assign cp_dn        = cp_dn_reg;
  assign cp_drive_en  = cp_drive_en_reg;
  assign cp_current   = cp_current_reg;
  assign cal_state    = cal_state_reg;

  // staged writes leave the hardware alone until the key arrives
  property p_no_update_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      !do_update |=> $stable(act_ctrl_reg) && $stable(act_route_reg);
  endproperty
  a_no_update_hold: assert property (p_no_update_hold) else $error("active changed"); // see RULE7
  property p_update_copy;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && do_update |=> act_ctrl_reg == $past(buf_ctrl_reg)
                          && act_vdiv_reg == $past(buf_vdiv_reg);
  endproperty
  a_update_copy: assert property (p_update_copy) else $error("update lost"); // see RULE7
  property p_power;
    @(posedge clk_sys) disable iff (!rst_n)
      ce ##1 ce |-> pll_pd_reg == ($past(act_ctrl_reg[`F_PWR]) != `PWR_NORMAL);
  endproperty
  a_power: assert property (p_power) else $error("power state wrong"); // see RULE2
  property p_bypass;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && do_update ##1 ce |=> vdiv_bypass_reg == $past(buf_route_reg[`F_BYP], 2);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong"); // see RULE3
  property p_source;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && do_update ##1 ce |=> dist_src_vco_reg == $past(buf_route_reg[`F_SRC], 2);
  endproperty
  a_source: assert property (p_source) else $error("source wrong"); // see RULE4
  property p_polarity;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && pll_on && cpm_norm && pol_neg && lnk.dn && !lnk.up |=> cp_up_reg && !cp_dn_reg;
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity swap wrong"); // see RULE8
  property p_hiz;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && (cpm_field == `CPM_HIZ) |=> !cp_drive_en_reg && !cp_up_reg && !cp_dn_reg;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pump not idle"); // see RULE12
  property p_current;
    @(posedge clk_sys) disable iff (!rst_n)
      ce |=> cp_current_reg == $past(act_cpcur_reg[`F_CPCUR]);
  endproperty
  a_current: assert property (p_current) else $error("pump current wrong"); // see RULE13
  property p_vdiv;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && do_update ##1 ce |=> vdiv_code_reg == $past(buf_vdiv_reg[`F_VDIV], 2);
  endproperty
  a_vdiv: assert property (p_vdiv) else $error("divider code wrong"); // see RULE16
  // a qualified start shows as running two edges later
  property p_cal_start;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && cal_start ##1 ce |=> cal_state_reg == CAL_RUN;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration not started"); // see RULE5
  // losing power or the vco source drops the sequencer to idle
  property p_cal_abort;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && cal_abort ##1 ce |=> cal_state_reg == CAL_IDLE;
  endproperty
  a_cal_abort: assert property (p_cal_abort) else $error("calibration not aborted"); // see RULE2
endmodule
`default_nettype wire

/* File: pll_route_defines.svh */
`ifndef PLL_ROUTE_DEFINES_SVH
`define PLL_ROUTE_DEFINES_SVH
// register port widths
`define ADDR_W          10
`define DATA_W          8
// register offsets
`define OFS_PLL_CTRL    10'h010
`define OFS_ABL         10'h017
`define OFS_CAL         10'h018
`define OFS_CPCUR       10'h01E
`define OFS_STATUS      10'h01F
`define OFS_VDIV        10'h1E0
`define OFS_ROUTE       10'h1E1
`define OFS_UPDATE      10'h232
`define UPDATE_KEY      8'h01
// field positions
`define F_PWR           1:0
`define F_CPM           6:4
`define F_POL           7
`define F_ABL           1:0
`define F_CAL           0
`define F_CPCUR         2:0
`define F_VDIV          2:0
`define F_BYP           0
`define F_SRC           1
`define F_ST_BUSY       0
`define F_ST_DONE       1
`define F_ST_PLLON      2
`define F_ST_UP         3
`define F_ST_DN         4
// reset values
`define RST_PLL_CTRL    8'h01
`define RST_ABL         8'h00
`define RST_CAL         8'h00
`define RST_CPCUR       8'h00
`define RST_VDIV        8'h02
`define RST_ROUTE       8'h00
// field codes
`define PWR_NORMAL      2'h0
`define PWR_DOWN        2'h1
`define CPM_HIZ         3'h0
`define CPM_UP          3'h1
`define CPM_DOWN        3'h2
`define CPM_NORMAL      3'h3
`define VDIV_MAX        3'h4
// calibration timing
`define CLK_PERIOD_NS   50
`define CAL_TIME_NS     10000
`define CAL_CYCLES      ((`CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_CNT_W       8
`endif

/* File: pll_route_pkg.sv */
`default_nettype none
package pll_route_pkg;
  // calibration sequencer states
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN  = 2'b01,
    CAL_DONE = 2'b10
  } cal_state_type;
endpackage
`default_nettype wire

/* File: pfd_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pfd_link_if;
  logic       ref_tick;  // r counter output pulse
  logic       fb_tick;   // n counter output pulse
  logic       run;       // detector enabled
  logic [1:0] abl_sel;   // antibacklash width select
  logic       up;        // raw pump-up request
  logic       dn;        // raw pump-down request
  modport ctrl (output ref_tick, output fb_tick, output run, output abl_sel,
                input up, input dn);
  modport pfd  (input ref_tick, input fb_tick, input run, input abl_sel,
                output up, output dn);
endinterface
`default_nettype wire

/* File: pfd_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pll_route_defines.svh"
module pfd_core (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic ce,
  pfd_link_if.pfd   lnk
);
  logic       up_reg;   // up flag, set by reference edge
  logic       dn_reg;   // down flag, set by feedback edge
  logic [1:0] abl_reg;  // overlap counter for antibacklash pulse
  wire        both = up_reg && dn_reg;
  wire        abl_end = both && (abl_reg == lnk.abl_sel);
  assign lnk.up = up_reg;
  assign lnk.dn = dn_reg;

  // flags: an arriving edge wins over the reset at pulse end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      up_reg  <= 1'b0;
      dn_reg  <= 1'b0;
      abl_reg <= 2'h0;
    end else if (ce) begin
      if (!lnk.run) begin
        up_reg  <= 1'b0;
        dn_reg  <= 1'b0;
        abl_reg <= 2'h0;
      end else begin
        up_reg  <= lnk.ref_tick || (up_reg && !abl_end); // see RULE11
        dn_reg  <= lnk.fb_tick || (dn_reg && !abl_end);  // see RULE11
        abl_reg <= (both && !abl_end) ? abl_reg + 2'h1 : 2'h0; // see RULE10
      end
    end
  end

  property p_ref_sets_up;
    @(posedge clk_sys) disable iff (!rst_n) ce && lnk.run && lnk.ref_tick |=> up_reg;
  endproperty
  a_ref_sets_up: assert property (p_ref_sets_up) else $error("ref edge lost"); // see RULE11
  property p_abl_width;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && lnk.run && abl_end && !lnk.ref_tick && !lnk.fb_tick |=> !up_reg && !dn_reg;
  endproperty
  a_abl_width: assert property (p_abl_width) else $error("antibacklash end wrong"); // see RULE10
endmodule
`default_nettype wire

/* File: vco_cal_seq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pll_route_defines.svh"
module vco_cal_seq (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  input  wire logic                       start,
  input  wire logic                       abort,
  output var  pll_route_pkg::cal_state_type state
);
  import pll_route_pkg::*;
  cal_state_type        state_reg;  // sequencer state
  cal_state_type        state_next;
  logic [`CAL_CNT_W-1:0] cnt_reg;   // cycles spent calibrating
  wire                  cnt_last = (cnt_reg == `CAL_CNT_W'(`CAL_CYCLES - 1));
  assign state = state_reg;

  // next state: abort beats everything, a fresh start restarts from done
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CAL_IDLE: state_next = start ? CAL_RUN : CAL_IDLE;
      CAL_RUN:  state_next = cnt_last ? CAL_DONE : CAL_RUN;
      CAL_DONE: state_next = start ? CAL_RUN : CAL_DONE;
      default:  state_next = CAL_IDLE;
    endcase
    if (abort) begin
      state_next = CAL_IDLE;
    end
  end

  // state and counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CAL_IDLE;
      cnt_reg   <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg   <= (state_reg == CAL_RUN && state_next == CAL_RUN) ? cnt_reg + 1'b1 : '0;
    end
  end
endmodule
`default_nettype wire

/* File: pll_far_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
// reference divider, feedback divider and loop filter seen from the control block
module pll_far_side_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  ref_per,
  input  wire logic [7:0]  fb_per,
  input  wire logic        cp_up,
  input  wire logic        cp_dn,
  input  wire logic        cp_drive_en,
  output logic             ref_tick,
  output logic             fb_tick,
  output logic      [15:0] tune_level
);
  logic [7:0] phase_reg;  // one shared phase, so equal periods give coincident edges

  // divider edges, one cycle wide; a period of zero silences that divider
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 8'h00;
      ref_tick  <= 1'b0;
      fb_tick   <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 8'h01;
      ref_tick  <= (ref_per != 8'h00) && ((phase_reg % ref_per) == 8'h00);
      fb_tick   <= (fb_per != 8'h00) && ((phase_reg % fb_per) == 8'h00);
    end
  end

  // loop filter: integrates pump current, holds its level while the pump floats
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tune_level <= 16'h8000;
    end else if (cp_drive_en && cp_up && !cp_dn) begin
      tune_level <= tune_level + 16'h0001;
    end else if (cp_drive_en && cp_dn && !cp_up) begin
      tune_level <= tune_level - 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* File: pll_source_routing_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pll_route_defines.svh"
module pll_source_routing_control_tb;
  import pll_route_pkg::*;
  logic                clk_sys   = 1'b0;  // 20 MHz system clock
  logic                rst_n     = 1'b0;  // held low for the first ten cycles
  logic                ce        = 1'b1;  // paused only for the dropped write in the reset test
  logic [`ADDR_W-1:0]  reg_addr  = '0;
  logic [`DATA_W-1:0]  reg_wdata = '0;
  logic                reg_wr    = 1'b0;
  logic                reg_rd    = 1'b0;
  logic [`DATA_W-1:0]  reg_rdata;
  logic                ref_tick, fb_tick, cp_up, cp_dn, cp_drive_en;
  logic                pll_pd, vco_pwr_en, dist_src_vco, vdiv_bypass;
  logic [2:0]          vdiv_code, cp_current;
  cal_state_type       cal_state;
  logic [7:0]          ref_per = 8'h00;  // far-side reference period, zero = silent
  logic [7:0]          fb_per  = 8'h00;  // far-side feedback period, zero = silent
  logic [15:0]         tune_level;
  logic [1:0]          pw, rt;          // power and route codes of the sweep
  int                  fail_count = 0;
  int                  n_tests = 0;
  int                  n, i;
  logic [7:0]          mode_val [5] = '{8'h30, 8'hB0, 8'h10, 8'h20, 8'h00};
  logic [2:0]          mode_exp [5] = '{3'b110, 3'b101, 3'b110, 3'b101, 3'b000};

  // free-running clock, 50 ns period
  always #25 clk_sys = ~clk_sys;

  pll_source_routing_control pll_source_routing_control_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_tick(ref_tick),
    .fb_tick(fb_tick), .pll_pd(pll_pd), .vco_pwr_en(vco_pwr_en), .dist_src_vco(dist_src_vco),
    .vdiv_bypass(vdiv_bypass), .vdiv_code(vdiv_code), .cp_up(cp_up), .cp_dn(cp_dn),
    .cp_drive_en(cp_drive_en), .cp_current(cp_current), .cal_state(cal_state));

  pll_far_side_model pll_far_side_model_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .ref_per(ref_per), .fb_per(fb_per), .cp_up(cp_up),
    .cp_dn(cp_dn), .cp_drive_en(cp_drive_en), .ref_tick(ref_tick), .fb_tick(fb_tick),
    .tune_level(tune_level));

  // compare and count; four-state compare so an unknown never matches
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t ns: got 0x%0h expected 0x%0h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe launched just after an edge
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle read strobe; data stands only in the following cycle
  task automatic rd_chk(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  // update write, then one more edge for the output registers to follow
  task automatic apply();
    wr(`OFS_UPDATE, `UPDATE_KEY);
    @(posedge clk_sys);
    #1;
  endtask

  task automatic done_test(input string s);
    $display("test %s finished", s);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog: the sequence needs a few thousand cycles at most
  initial begin
    #(50 * 30000);
    fail_count++;
    $display("ERROR at %0t ns: watchdog expired, got 0x0 expected 0x1", $time);
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1 check({pll_pd, vco_pwr_en, dist_src_vco, vdiv_bypass, 1'b0, vdiv_code}, 8'h82);
    check({cp_up, cp_dn, cp_drive_en, cp_current, cal_state}, 8'h00);
    rd_chk(`OFS_PLL_CTRL, `RST_PLL_CTRL);
    rd_chk(`OFS_VDIV, `RST_VDIV);
    rd_chk(`OFS_ROUTE, `RST_ROUTE);
    rd_chk(`OFS_UPDATE, 8'h00);
    rd_chk(10'h3FF, 8'h00);
    // a write made while the clock enable is low must leave no trace
    ce <= 1'b0;
    wr(`OFS_CPCUR, 8'h05);
    ce <= 1'b1;
    rd_chk(`OFS_CPCUR, `RST_CPCUR);
    done_test("reset");
    // staged values stay inactive until the exact update key arrives
    wr(`OFS_PLL_CTRL, 8'h30);
    wr(`OFS_ROUTE, 8'h02);
    wr(`OFS_VDIV, 8'h00);
    rd_chk(`OFS_PLL_CTRL, 8'h30);
    wr(`OFS_UPDATE, 8'h02);
    repeat (2) @(posedge clk_sys);
    #1 check({pll_pd, vco_pwr_en, dist_src_vco, vdiv_bypass, 1'b0, vdiv_code}, 8'h82);
    apply();
    check({pll_pd, vco_pwr_en, dist_src_vco, vdiv_bypass, 1'b0, vdiv_code}, 8'h60);
    done_test("update");
    // sweep power, route, divider and pump current codes, reserved ones included
    for (i = 0; i < 8; i++) begin
      pw = i[1:0];
      rt = i[2:1];
      wr(`OFS_PLL_CTRL, {6'h00, pw});
      wr(`OFS_ROUTE, {6'h00, rt});
      wr(`OFS_VDIV, 8'(i));
      wr(`OFS_CPCUR, 8'(i));
      apply();
      check({pll_pd, vco_pwr_en, dist_src_vco, vdiv_bypass, 1'b0, vdiv_code},
            {pw != 2'h0, pw == 2'h0 && rt[1], rt, 1'b0, 3'(i)});
      check({5'h00, cp_current}, 8'(i));
    end
    done_test("routing");
    // calibration start, length, refused restart, reset-then-restart, abort
    ref_per <= 8'h08;
    wr(`OFS_ROUTE, 8'h02);
    wr(`OFS_PLL_CTRL, 8'h30);
    wr(`OFS_CAL, 8'h01);
    apply();
    check({6'h00, cal_state}, {6'h00, CAL_RUN});
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (cal_state === CAL_RUN && n < 1000);
    check(8'(n), 8'(`CAL_CYCLES));
    check({6'h00, cal_state}, {6'h00, CAL_DONE});
    rd_chk(`OFS_STATUS, 8'h0E);
    wr(`OFS_CAL, 8'h01);
    apply();
    check({6'h00, cal_state}, {6'h00, CAL_DONE});
    wr(`OFS_CAL, 8'h00);
    apply();
    wr(`OFS_CAL, 8'h01);
    apply();
    check({6'h00, cal_state}, {6'h00, CAL_RUN});
    wr(`OFS_PLL_CTRL, 8'h31);
    apply();
    check({6'h00, cal_state}, {6'h00, CAL_IDLE});
    done_test("calibration");
    // detector latency: first reference edge after power-up reaches the pump two edges later
    ref_per <= 8'h00;
    wr(`OFS_PLL_CTRL, 8'h30);
    apply();
    ref_per <= 8'h08;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (!ref_tick && n < 64);
    @(posedge clk_sys);
    #1 check({7'h00, cp_up}, 8'h00);
    @(posedge clk_sys);
    #1 check({7'h00, cp_up}, 8'h01);
    // pump modes and polarity, reference running with the feedback divider silent
    for (i = 0; i < 5; i++) begin
      wr(`OFS_PLL_CTRL, mode_val[i]);
      apply();
      repeat (2) @(posedge clk_sys);
      #1 check({7'h00, cp_drive_en}, {7'h00, mode_exp[i][2]});
      if (mode_exp[i][2]) begin
        check({6'h00, cp_up, cp_dn}, {6'h00, mode_exp[i][1:0]});
      end
    end
    done_test("pump");
    // coincident edges: overlap width follows the antibacklash code
    for (i = 0; i < 4; i++) begin
      ref_per <= 8'h00;
      fb_per  <= 8'h00;
      wr(`OFS_PLL_CTRL, 8'h31);
      wr(`OFS_ABL, 8'(i));
      apply();
      wr(`OFS_PLL_CTRL, 8'h30);
      apply();
      ref_per <= 8'h10;
      fb_per  <= 8'h10;
      n = 0;
      do begin
        @(posedge clk_sys);
        #1 n++;
      end while (!cp_up && n < 64);
      n = 0;
      while (cp_up && n < 20) begin
        @(posedge clk_sys);
        #1 n++;
      end
      check(8'(n), 8'(i + 1));
    end
    done_test("antibacklash");
    print_verdict();
  end
endmodule
`default_nettype wire
